// file: src/scb_pkg.sv
/*
  Constants and types of the SPI command bridge: command codes,
  error codes, address limits, frame sizes and the register map.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package scb_pkg;
  // Command codes, bits 15:8 of MOSI word 0.
  localparam logic [7:0] CMD_STORE  = 8'h02;
  localparam logic [7:0] CMD_FETCH  = 8'h03;
  localparam logic [7:0] CMD_COMMIT = 8'h04;
  localparam logic [7:0] CMD_DRAIN  = 8'h05;
  localparam logic [7:0] CMD_FILL   = 8'h06;
  // Status codes kept for software.
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_CMD  = 16'h0001;
  localparam logic [15:0] ERR_LEN  = 16'h0002;
  localparam logic [15:0] ERR_ADDR = 16'h0003;
  localparam logic [15:0] ERR_SEQ  = 16'h0004;
  // Address limits and the staging buffer base.
  localparam logic [15:0] STORE_ADDR_MAX = 16'h3FFF;
  localparam logic [15:0] CORE_ADDR_MAX  = 16'h2FFF;
  localparam logic [13:0] STAGE_BASE     = 14'h3020;
  localparam logic [7:0]  LEN_STORE_MAX  = 8'h02;
  localparam logic [7:0]  LEN_CHUNK_MAX  = 8'h04;
  // Frame shape: three 16-bit words, MSB first.
  localparam logic [5:0] FRAME_BITS = 6'h30;
  localparam logic [5:0] WORD0_BITS = 6'h10;
  // Register map on the AXI4-Lite slave.
  localparam logic [7:0] AXI_STATUS  = 8'h00;
  localparam logic [7:0] AXI_CONTROL = 8'h04;
  localparam logic [7:0] AXI_TALLY   = 8'h08;
  localparam int         CTRL_CLR_BIT = 0;
  localparam int         STAT_BUSY_BIT = 16;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_XFER = 2'h2
  } scb_eng_t;

  typedef struct packed {
    logic [2:0]        sck_s;
    logic [2:0]        ssn_s;
    logic [2:0]        mosi_s;
    logic              sck_f;
    logic              ssn_f;
    logic [5:0]        bitcnt;
    logic [47:0]       rx;
    logic [47:0]       tx;
    logic              miso;
    logic              err;
    logic [13:0]       echo;
    logic [15:0]       code;
    scb_eng_t          eng;
    logic              we;
    logic              src_pair;
    logic              mreq;
    logic [13:0]       maddr;
    logic [7:0]        mwdata;
    logic [7:0]        cnt;
    logic [7:0]        len;
    logic [15:0]       pair;
    logic [13:0]       fbase;
    logic [6:0]        nent;
    logic [6:0]        idx;
    logic              prev_fill;
    logic [15:0]       tally;
    logic [63:0][31:0] stage;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
  } scb_regs_t;
endpackage
`default_nettype wire

// file: src/scb_bridge.sv
/*
  SPI slave command bridge: takes three-word frames from the host,
  runs single and sequential accesses on the core memory port and
  holds a 64-entry staging buffer. Status over AXI4-Lite.
  Assumes SPI mode with an idle-low clock, data sampled on falling
  edges, MEM_RDATA/MEM_ACK synchronous to CLK.
*/
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Frame is three 16-bit words each way.
// - Code 02 writes word 2 at word 1.
// - Store byte count only one or two.
// - Store address limited to 0000..3FFF.
// - One-byte store payload sits in upper byte.
// - Reply word 0: error, busy, echoed address.
// - Code 03 reads core bytes into staging.
// - Sequence byte count at most 255.
// - Fetch address limited to 0000..2FFF.
// - Code 04 copies staging bytes into core.
// - Code 05 returns next entry from zero.
// - Drain data in words 1,2, left-justified.
// - Drain echoes core address that was read.
// - Code 06 stores next entry from zero.
// - Fill count 1..4, payload left-justified.
// - Fill echoes staging entry address.
// - Busy stays set while fetch runs.
// - Words 1,2 meaningless for other commands.
// - Staging is 64 words at 3020 step 4.
// - Out-of-order drain or fill records 0004.
// - Tally holds staging entries of last sequence.
module scb_bridge
  import scb_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        SCK,
  input  wire logic        CS_N,
  input  wire logic        MOSI,
  output logic             MISO,
  output logic             MEM_REQ,
  output logic             MEM_WE,
  output logic [13:0]      MEM_ADDR,
  output logic [7:0]       MEM_WDATA,
  input  wire logic [7:0]  MEM_RDATA,
  input  wire logic        MEM_ACK,
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY
);

  scb_regs_t   st;
  scb_regs_t   nx;
  logic        busy;
  logic        frame_start;
  logic        frame_end;
  logic        sck_fall;
  logic        exec;
  logic        aw_go;
  logic [15:0] w0;
  logic [15:0] w1;
  logic [15:0] w2;

  // Byte k of a left-justified word; lane 0 is the top byte.
  function automatic logic [7:0] lane_get(input logic [31:0] w,
                                          input logic [1:0] l);
    case (l)
      2'h0:    lane_get = w[31:24];
      2'h1:    lane_get = w[23:16];
      2'h2:    lane_get = w[15:8];
      default: lane_get = w[7:0];
    endcase
  endfunction

  function automatic logic [31:0] lane_put(input logic [31:0] w,
                                           input logic [1:0] l,
                                           input logic [7:0] b);
    lane_put = w;
    case (l)
      2'h0:    lane_put[31:24] = b;
      2'h1:    lane_put[23:16] = b;
      2'h2:    lane_put[15:8] = b;
      default: lane_put[7:0] = b;
    endcase
  endfunction

  // Keeps the first n bytes so that short chunks read as zero below.
  function automatic logic [31:0] keep_mask(input logic [7:0] n);
    keep_mask = ~(32'hFFFFFFFF >> {n[2:0], 3'h0});
  endfunction

  function automatic logic chunk_ok(input logic [7:0] n);
    chunk_ok = (n != 8'h00) && (n <= LEN_CHUNK_MAX);
  endfunction

  // Edge finding on the filtered pins; the first stage feeds only the second.
  assign busy        = (st.eng != ST_IDLE);
  assign frame_start = (st.ssn_s[1] == st.ssn_s[2]) && !st.ssn_s[2] && st.ssn_f;
  assign frame_end   = (st.ssn_s[1] == st.ssn_s[2]) && st.ssn_s[2] && !st.ssn_f;
  assign sck_fall    = (st.sck_s[1] == st.sck_s[2]) && !st.sck_s[2] && st.sck_f
                       && !st.ssn_f;
  assign exec        = frame_end && (st.bitcnt == FRAME_BITS);
  assign w0          = st.rx[47:32];
  assign w1          = st.rx[31:16];
  assign w2          = st.rx[15:0];
  assign aw_go       = AWVALID && WVALID && !st.bvalid;

  // Bus ready signals are combinational; BVALID, RVALID and all data come from flip-flops.
  assign AWREADY   = aw_go;
  assign WREADY    = aw_go;
  assign ARREADY   = !st.rvalid;
  assign BVALID    = st.bvalid;
  assign BRESP     = st.bresp;
  assign RVALID    = st.rvalid;
  assign RRESP     = st.rresp;
  assign RDATA     = st.rdata;
  assign MISO      = st.miso;
  assign MEM_REQ   = st.mreq;
  assign MEM_WE    = st.we;
  assign MEM_ADDR  = st.maddr;
  assign MEM_WDATA = st.mwdata;

  // Next state of the whole block.
  always_comb begin
    logic [15:0] e;
    logic [6:0]  fi;
    logic [7:0]  n;
    logic [7:0]  c1;
    e  = ERR_NONE;
    fi = '0;
    n  = w0[7:0];
    c1 = 8'(st.cnt + 8'h01);
    nx = st;
    nx.sck_s  = {st.sck_s[1:0], SCK};
    nx.ssn_s  = {st.ssn_s[1:0], CS_N};
    nx.mosi_s = {st.mosi_s[1:0], MOSI};
    if (st.sck_s[1] == st.sck_s[2]) begin
      nx.sck_f = st.sck_s[2];
    end
    if (st.ssn_s[1] == st.ssn_s[2]) begin
      nx.ssn_f = st.ssn_s[2];
    end

    // Frame start loads the reply word 0 from the last command's result.
    if (frame_start) begin
      nx.bitcnt = '0;
      nx.tx     = {st.err, busy, st.echo, 32'h0};
      nx.miso   = st.err;
    end
    // The host samples on falling edges, so the next bit moves out right after one.
    if (sck_fall && (st.bitcnt != FRAME_BITS)) begin
      nx.bitcnt = 6'(st.bitcnt + 6'h01);
      nx.rx     = {st.rx[46:0], st.mosi_s[2]};
      nx.tx     = {st.tx[46:0], 1'b0};
      if ((nx.bitcnt == WORD0_BITS) && (nx.rx[15:8] == CMD_DRAIN)) begin
        nx.tx[47:16] = st.stage[st.idx[5:0]] & keep_mask(nx.rx[7:0]);
      end
      nx.miso = nx.tx[47];
    end

    // Memory engine: one byte per MEM_ACK.
    if (busy && MEM_ACK) begin
      if (!st.we) begin
        nx.stage[st.cnt[7:2]] = lane_put(st.stage[st.cnt[7:2]], st.cnt[1:0],
                                         MEM_RDATA);
      end
      nx.cnt = c1;
      if (c1 == st.len) begin
        nx.eng  = ST_IDLE;
        nx.mreq = 1'b0;
      end else begin
        nx.maddr  = 14'(st.maddr + 14'h0001);
        nx.mwdata = st.src_pair ? st.pair[7:0]
                                : lane_get(st.stage[c1[7:2]], c1[1:0]);
      end
    end

    // A software clear loses to an error raised in the same cycle.
    if (aw_go && (AWADDR == AXI_CONTROL) && WSTRB[0] && WDATA[CTRL_CLR_BIT]) begin
      nx.code = ERR_NONE;
    end

    // Command checks at the end of a complete frame.
    if (exec) begin
      fi = st.prev_fill ? st.idx : 7'h00;
      case (w0[15:8])
        CMD_STORE: begin
          if ((n == 8'h00) || (n > LEN_STORE_MAX)) e = ERR_LEN;
          else if (w1 > STORE_ADDR_MAX) e = ERR_ADDR;
          else if (busy) e = ERR_SEQ;
        end
        CMD_FETCH, CMD_COMMIT: begin
          if (n == 8'h00) e = ERR_LEN;
          else if (w1 > CORE_ADDR_MAX) e = ERR_ADDR;
          else if (busy) e = ERR_SEQ;
        end
        CMD_DRAIN: begin
          if (!chunk_ok(n)) e = ERR_LEN;
          else if (busy || (st.idx >= st.nent)) e = ERR_SEQ;
        end
        CMD_FILL: begin
          if (!chunk_ok(n)) e = ERR_LEN;
          else if (busy || fi[6]) e = ERR_SEQ;
        end
        default: e = ERR_CMD;
      endcase
      nx.err       = (e != ERR_NONE);
      nx.echo      = w1[13:0];
      nx.prev_fill = 1'b0;
      if (e != ERR_NONE) begin
        nx.code = e;
      end else begin
        case (w0[15:8])
          CMD_STORE: begin
            nx.eng      = ST_XFER;
            nx.we       = 1'b1;
            nx.src_pair = 1'b1;
            nx.pair     = w2;
            nx.mwdata   = w2[15:8];
          end
          CMD_FETCH: begin
            nx.eng      = ST_XFER;
            nx.we       = 1'b0;
            nx.fbase    = w1[13:0];
            nx.nent     = 7'((9'(n) + 9'h003) >> 2);
            nx.tally    = 16'(nx.nent);
          end
          CMD_COMMIT: begin
            nx.eng      = ST_XFER;
            nx.we       = 1'b1;
            nx.src_pair = 1'b0;
            nx.mwdata   = st.stage[0][31:24];
            nx.tally    = 16'(7'((9'(n) + 9'h003) >> 2));
          end
          CMD_DRAIN: begin
            nx.echo = 14'(st.fbase + 14'({st.idx[5:0], 2'h0}));
            nx.idx  = 7'(st.idx + 7'h01);
          end
          default: begin
            nx.stage[fi[5:0]] = {w1, w2} & keep_mask(n);
            nx.echo      = 14'(STAGE_BASE + 14'({fi[5:0], 2'h0}));
            nx.idx       = 7'(fi + 7'h01);
            nx.prev_fill = 1'b1;
          end
        endcase
        if (nx.eng == ST_XFER) begin
          nx.len   = n;
          nx.cnt   = '0;
          nx.maddr = w1[13:0];
          nx.mreq  = 1'b1;
          nx.idx   = '0;
        end
      end
    end

    // AXI4-Lite write side: only the control register takes writes.
    if (aw_go) begin
      nx.bvalid = 1'b1;
      nx.bresp  = (AWADDR == AXI_CONTROL) ? RESP_OKAY : RESP_SLVERR;
    end else if (st.bvalid && BREADY) begin
      nx.bvalid = 1'b0;
    end
    // AXI4-Lite read side; unmapped words answer SLVERR with zero data.
    if (ARVALID && !st.rvalid) begin
      nx.rvalid = 1'b1;
      nx.rresp  = RESP_OKAY;
      nx.rdata  = '0;
      case (ARADDR)
        AXI_STATUS: begin
          nx.rdata[15:0]          = st.code;
          nx.rdata[STAT_BUSY_BIT] = busy;
        end
        AXI_TALLY:  nx.rdata[15:0] = st.tally;
        default:    nx.rresp = RESP_SLVERR;
      endcase
    end else if (st.rvalid && RREADY) begin
      nx.rvalid = 1'b0;
    end
  end

  // Single register stage for all state; pins reset to idle-high select.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st       <= '0;
      st.sck_s <= '0;
      st.ssn_s <= 3'h7;
      st.ssn_f <= 1'b1;
      st.eng   <= ST_IDLE;
    end else begin
      st <= nx;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  property p_store;
    exec && (w0[15:8] == CMD_STORE) && (w0[7:0] == 8'h01) && (w1 <= CORE_ADDR_MAX)
      && !busy |=> MEM_REQ && MEM_WE && (MEM_ADDR == $past(w1[13:0]))
      && (MEM_WDATA == $past(w2[15:8]));
  endproperty
  a_store: assert property (p_store)
    else $error("store did not start a write of the upper byte");

  property p_len;
    exec && (w0[15:8] == CMD_STORE) && (w0[7:0] > LEN_STORE_MAX)
      |=> st.err && (st.code == ERR_LEN) && (!MEM_REQ || $past(busy));
  endproperty
  a_len: assert property (p_len)
    else $error("bad store length not flagged");

  property p_addr;
    exec && (w0[15:8] == CMD_STORE) && (w0[7:0] == 8'h02) && (w1 > STORE_ADDR_MAX)
      |=> (st.code == ERR_ADDR) && (!MEM_REQ || $past(busy));
  endproperty
  a_addr: assert property (p_addr)
    else $error("store address above limit not flagged");

  property p_frange;
    exec && (w0[15:8] == CMD_FETCH) && (w1 > CORE_ADDR_MAX)
      |=> (st.code == ERR_ADDR) && st.err;
  endproperty
  a_frange: assert property (p_frange)
    else $error("fetch address outside core not flagged");

  property p_fbusy;
    exec && (w0[15:8] == CMD_FETCH) && (w0[7:0] != 8'h00)
      && (w1 <= CORE_ADDR_MAX) && !busy |=> busy && (st.idx == 7'h00) ##1 busy;
  endproperty
  a_fbusy: assert property (p_fbusy)
    else $error("fetch did not raise busy or reset the index");

  property p_hold;
    busy && !MEM_ACK |=> busy && $stable(st.maddr);
  endproperty
  a_hold: assert property (p_hold)
    else $error("busy dropped without a memory acknowledge");

  property p_fill;
    exec && (w0[15:8] == CMD_FILL) && (w0[7:0] == 8'h04) && st.prev_fill
      && !st.idx[6] && !busy |=> (st.idx == 7'($past(st.idx) + 7'h01))
      && (st.echo == 14'(STAGE_BASE + 14'({$past(st.idx[5:0]), 2'h0})));
  endproperty
  a_fill: assert property (p_fill)
    else $error("fill did not advance index or echo its entry");

  property p_tx;
    frame_start |=> (st.tx[47] == $past(st.err)) && (st.tx[46] == $past(busy));
  endproperty
  a_tx: assert property (p_tx)
    else $error("reply word 0 flags not loaded at frame start");

  property p_seq;
    exec && (w0[15:8] == CMD_DRAIN) && chunk_ok(w0[7:0]) && (st.idx >= st.nent)
      |=> (st.code == ERR_SEQ);
  endproperty
  a_seq: assert property (p_seq)
    else $error("drain past fetched data not flagged");

endmodule // scb_bridge

`default_nettype wire

// file: bench/scb_host_model.sv
/*
  Host microcontroller model: SPI master sending three-word frames.
  Assumes the bridge samples MOSI on SCK falls and shifts MISO after them.
*/
`timescale 1ns/100ps
`default_nettype none
module scb_host_model (
  output logic      SCK,
  output logic      CS_N,
  output logic      MOSI,
  input  wire logic MISO
);
  initial begin
    SCK = 1'b0;
    CS_N = 1'b1;
    MOSI = 1'b0;
  end

  // One full-duplex frame, MSB first; MISO is taken late in the high phase.
  task automatic xfer(input logic [47:0] m, output logic [47:0] r);
    // Select falls between system clock edges so that no edge races it.
    #3;
    CS_N = 1'b0;
    #100;
    for (int i = 47; i >= 0; i--) begin
      MOSI = m[i];
      SCK = 1'b1;
      #40;
      r[i] = MISO;
      SCK = 1'b0;
      #40;
    end
    CS_N = 1'b1;
    // The line is driven to the inverse, so it no longer shows the last bit.
    MOSI = ~MOSI;
    #300;
  endtask
endmodule  // scb_host_model
`default_nettype wire

// file: bench/scb_bridge_tb_top.sv
/*
  Self-checking bench of the SPI command bridge with a core memory model.
  Assumes the host model drives the link and AXI4-Lite reads status.
*/
`timescale 1ns/100ps
`default_nettype none
module scb_bridge_tb_top
  import scb_pkg::*;
;
  logic        CLK, RST, SCK, CS_N, MOSI, MISO, MEM_REQ, MEM_WE, MEM_ACK, slow;
  logic        AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic        ARVALID, ARREADY, RVALID, RREADY;
  logic [13:0] MEM_ADDR, fbase;
  logic [7:0]  MEM_WDATA, MEM_RDATA, AWADDR, ARADDR, lastc, mem [16384];
  logic [31:0] WDATA, RDATA, rd, expd, fillq [64];
  logic [3:0]  WSTRB;
  logic [1:0]  BRESP, RRESP, rr;
  logic [47:0] rep;
  logic [15:0] exp0, ec;
  logic [5:0]  dly;
  int          n_mismatch, compares, n_wr, idx, fidx, nfet, tal, l;

  scb_bridge i_dut (
    .CLK(CLK), .RST(RST), .SCK(SCK), .CS_N(CS_N), .MOSI(MOSI), .MISO(MISO),
    .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA),
    .MEM_RDATA(MEM_RDATA), .MEM_ACK(MEM_ACK), .AWADDR(AWADDR), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
    .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY));
  scb_host_model i_host (.SCK(SCK), .CS_N(CS_N), .MOSI(MOSI), .MISO(MISO));

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  // Core memory acks each byte after a short or a long stall; idle data toggles.
  always @(posedge CLK) begin
    if (RST) begin
      MEM_ACK <= 1'b0;
      MEM_RDATA <= 8'h00;
      dly <= 6'h00;
      for (int a = 0; a < 16384; a++) mem[a] <= 8'(a ^ (a >> 6) ^ 8'h5A);
    end else begin
      MEM_ACK <= 1'b0;
      MEM_RDATA <= ~MEM_RDATA;
      if (MEM_REQ === 1'b1 && !MEM_ACK) begin
        if (dly != 0) dly <= dly - 6'h01;
        else begin
          MEM_ACK <= 1'b1;
          MEM_RDATA <= mem[MEM_ADDR];
          dly <= slow ? 6'h1E : 6'($urandom % 3);
          if (MEM_WE) begin
            mem[MEM_ADDR] <= MEM_WDATA;
            n_wr++;
          end
        end
      end
    end
  end

  function automatic int ent(input int n);
    return (n + 3) / 4;
  endfunction

  task automatic results();
    $display("Counts: %0d compares, %0d mismatches", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic tmo(input int n);
    if (n >= 999) begin
      n_mismatch++;
      $display("Error at %0t: wait ran out, got %0h expected %0h", $time, n, 0);
      results();
    end
  endtask

  // Bounded wait on AWREADY, BVALID, RVALID or ARREADY at a rising edge.
  task automatic wt_hi(input int w);
    int n;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (!(w == 0 ? (AWREADY === 1'b1 && WREADY === 1'b1) : w == 1 ? BVALID === 1'b1 :
                 w == 2 ? RVALID === 1'b1 : ARREADY === 1'b1) && n < 999);
    tmo(n);
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    wt_hi(0);
    AWVALID <= 1'b0;
    WVALID <= 1'b0;
    BREADY <= 1'b1;
    wt_hi(1);
    rr = BRESP;
    BREADY <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a);
    @(posedge CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    wt_hi(3);
    ARVALID <= 1'b0;
    RREADY <= 1'b1;
    wt_hi(2);
    rd = RDATA;
    rr = RRESP;
    RREADY <= 1'b0;
  endtask

  task automatic idle();
    int n;
    n = 0;
    do begin
      axr(AXI_STATUS);
      n++;
    end while (rd[STAT_BUSY_BIT] !== 1'b0 && n < 999);
    tmo(n);
  endtask

  // Each reply word 0 is judged against the status of the command before it.
  task automatic cmd(input logic [7:0] c, n, input logic [15:0] w1, w2, ce,
                     input logic [13:0] ea, input logic wt);
    i_host.xfer({c, n, w1, w2}, rep);
    chk(rep[47:32], exp0);
    if (c == CMD_DRAIN && ce == ERR_NONE) chk(rep[31:0], expd);
    exp0 = {ce != ERR_NONE, 1'b0, ea};
    if (ce != ERR_NONE) ec = ce;
    // A refused command breaks a run of fills, as in the bridge.
    lastc = (ce == ERR_NONE) ? c : 8'h00;
    if (wt) begin
      idle();
      chk(rd, {16'h0000, ec});
    end
  endtask

  task automatic store(input logic [15:0] a, input logic [7:0] n, input logic [15:0] d);
    int w;
    logic [15:0] ce;
    w = n_wr;
    ce = (n == 0 || n > LEN_STORE_MAX) ? ERR_LEN : (a > STORE_ADDR_MAX) ? ERR_ADDR : ERR_NONE;
    cmd(CMD_STORE, n, a, d, ce, a[13:0], 1'b1);
    chk(n_wr - w, ce == ERR_NONE ? n : 0);
    if (ce == ERR_NONE) chk(mem[a[13:0]], d[15:8]);
    if (ce == ERR_NONE && n == 2) chk(mem[a[13:0] + 14'h1], d[7:0]);
  endtask

  task automatic fetch(input logic [15:0] a, input logic [7:0] n, input logic wt);
    logic [15:0] ce;
    ce = (n == 0) ? ERR_LEN : (a > CORE_ADDR_MAX) ? ERR_ADDR : ERR_NONE;
    if (ce == ERR_NONE) begin
      fbase = a[13:0];
      nfet = n;
      idx = 0;
      tal = ent(n);
    end
    cmd(CMD_FETCH, n, a, 16'h0000, ce, a[13:0], wt);
    if (wt) axr(AXI_TALLY);
    if (wt) chk(rd, tal);
  endtask

  task automatic drain(input logic [7:0] n);
    int ok;
    logic [15:0] ce;
    ce = (n == 0 || n > LEN_CHUNK_MAX) ? ERR_LEN : (idx < ent(nfet)) ? ERR_NONE : ERR_SEQ;
    ok = (ce == ERR_NONE);
    expd = 32'h0;
    for (int k = 0; k < n && ok; k++) expd[31 - 8 * k -: 8] = mem[fbase + 4 * idx + k];
    cmd(CMD_DRAIN, n, 16'h1234, 16'h0000, ce,
        ok ? fbase + 14'(4 * idx) : 14'h1234, 1'b1);
    idx += ok;
  endtask

  task automatic fill(input logic [7:0] n, input logic [31:0] d);
    int ok;
    logic [15:0] ce;
    if (lastc != CMD_FILL) fidx = 0;
    ce = (n == 0 || n > LEN_CHUNK_MAX) ? ERR_LEN : (fidx < 64) ? ERR_NONE : ERR_SEQ;
    ok = (ce == ERR_NONE);
    cmd(CMD_FILL, n, d[31:16], d[15:0], ce,
        ok ? STAGE_BASE + 14'(4 * fidx) : d[29:16], 1'b1);
    if (ok) fillq[fidx] = d;
    fidx += ok;
  endtask

  task automatic commit(input logic [15:0] a, input logic [7:0] n);
    int w;
    w = n_wr;
    tal = ent(n);
    cmd(CMD_COMMIT, n, a, 16'h0000, ERR_NONE, a[13:0], 1'b1);
    chk(n_wr - w, n);
    for (int k = 0; k < n; k++) chk(mem[a[13:0] + 14'(k)], fillq[k / 4][31 - 8 * (k % 4) -: 8]);
    axr(AXI_TALLY);
    chk(rd, tal);
  endtask

  // Main sequence: stores, faults, fetch and drain, fill and commit.
  initial begin
    RST = 1'b1;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY, slow} = 6'h00;
    {AWADDR, ARADDR, WDATA, exp0, ec} = 0;
    WSTRB = 4'hF;
    lastc = 8'h00;
    void'($urandom(96252));
    repeat (8) @(posedge CLK);
    RST <= 1'b0;
    axr(AXI_STATUS);
    chk(rd, 32'h0);
    for (int i = 0; i < 6; i++) store(16'($urandom % 16'h3000), 8'($urandom % 2 + 1), 16'($urandom));
    store(16'h3FFF, 8'h01, 16'hA55A);
    store(16'h4000, 8'h02, 16'h1111);
    store(16'h0100, 8'h03, 16'h2222);
    store(16'h0100, 8'h00, 16'h3333);
    cmd(8'h01, 8'h02, 16'h0ABC, 16'h0000, ERR_CMD, 14'h0ABC, 1'b1);
    cmd(8'h07, 8'h02, 16'h0123, 16'h0000, ERR_CMD, 14'h0123, 1'b1);
    axw(AXI_CONTROL, 32'h1);
    chk(rr, RESP_OKAY);
    ec = ERR_NONE;
    axr(AXI_STATUS);
    chk(rd, 32'h0);
    axw(AXI_STATUS, 32'h1);
    chk(rr, RESP_SLVERR);
    axr(8'h0C);
    chk(rr, RESP_SLVERR);
    chk(rd, 32'h0);
    $display("Test store done");
    fetch(16'h3000, 8'h04, 1'b1);
    fetch(16'h0010, 8'h00, 1'b1);
    fetch(16'h2F01, 8'hFF, 1'b1);
    drain(8'h04);
    drain(8'h04);
    slow = 1'b1;
    fetch(16'h0200, 8'h28, 1'b0);
    exp0[14] = 1'b1;
    axr(AXI_STATUS);
    chk(rd[STAT_BUSY_BIT], 1'b1);
    cmd(CMD_DRAIN, 8'h04, 16'h1234, 16'h0000, ERR_SEQ, 14'h1234, 1'b1);
    slow = 1'b0;
    for (int i = 0; i < 11; i++) drain(8'h04);
    l = 5 + $urandom % 20;
    fetch(16'($urandom % 16'h2F00), 8'(l), 1'b1);
    for (int r = l; r > 0; r -= 4) drain(8'(r > 4 ? 4 : r));
    drain(8'h05);
    $display("Test fetch done");
    l = 5 + $urandom % 20;
    for (int r = l; r > 0; r -= 4) fill(8'(r > 4 ? 4 : r), $urandom);
    commit(16'($urandom % 16'h2F00), 8'(l));
    fill(8'h05, 32'h0);
    for (int i = 0; i < 65; i++) fill(8'h04, $urandom);
    commit(16'h2F01, 8'hFF);
    store(16'h0004, 8'h01, 16'h7700);
    $display("Test fill done");
    results();
  end
endmodule  // scb_bridge_tb_top
`default_nettype wire
